// [logic/fetch_decode_pkg.sv]
// Constants, types and decode helpers shared by the instruction fetch and decode logic.
package fetch_decode_pkg;

  localparam int PC_W = 21;
  localparam int WORD_W = 16;
  localparam int LIT_W = 12;
  localparam int BRA_OFF_W = 11;

  // Reset value and step of the byte-addressed program counter.
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;

  // Top nibble that marks the second word of a two-word instruction.
  localparam logic [3:0] ESC_NIB = 4'hf;

  // First-word opcode patterns.
  localparam logic [7:0] OP_CALL_HI = 8'hec;
  localparam logic [7:0] OP_GOTO_HI = 8'hef;
  localparam logic [7:0] OP_LIT_HI = 8'hee;
  localparam logic [3:0] OP_MOVE_NIB = 4'hc;
  localparam logic [4:0] OP_BRA_HI = 5'h1a;

  // Fetch sequencer states, one-hot.
  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_WAIT = 2'b10
  } fetch_state_e;

  // Word classes seen by the decoder.
  typedef enum logic [2:0] {
    CL_SINGLE = 3'h0,
    CL_CALL = 3'h1,
    CL_GOTO = 3'h2,
    CL_MOVE = 3'h3,
    CL_LIT = 3'h4,
    CL_BRA = 3'h5,
    CL_ESC = 3'h6
  } word_class_e;

  // True when the word carries the escape pattern in its top nibble.
  function automatic logic is_escape(input logic [15:0] w);
    is_escape = (w[15:12] == ESC_NIB);
  endfunction : is_escape

  // Sort a fetched word into its class.
  function automatic word_class_e classify(input logic [15:0] w);
    if (is_escape(w))
      classify = CL_ESC;
    else if (w[15:8] == OP_CALL_HI)
      classify = CL_CALL;
    else if (w[15:8] == OP_GOTO_HI)
      classify = CL_GOTO;
    else if (w[15:8] == OP_LIT_HI)
      classify = CL_LIT;
    else if (w[15:12] == OP_MOVE_NIB)
      classify = CL_MOVE;
    else if (w[15:11] == OP_BRA_HI)
      classify = CL_BRA;
    else
      classify = CL_SINGLE;
  endfunction : classify

  // True for the first word of any two-word instruction.
  function automatic logic is_two_word(input word_class_e c);
    is_two_word = (c == CL_CALL) || (c == CL_GOTO) || (c == CL_MOVE) || (c == CL_LIT);
  endfunction : is_two_word

  // Absolute word target as a byte address: word address lands in bits 20 to 1.
  function automatic logic [20:0] abs_target(input logic [15:0] first, input logic [15:0] second);
    abs_target = {first[7:0], second[11:0], 1'b0};
  endfunction : abs_target

  // Relative target: offset counts words, so it is doubled before the add.
  function automatic logic [20:0] rel_target(input logic [20:0] pc, input logic [15:0] w);
    rel_target = pc + PC_STEP + {{9{w[10]}}, w[10:0], 1'b0};
  endfunction : rel_target

endpackage : fetch_decode_pkg

// [logic/pc_next_unit.sv]
// Next program counter selection for the fetch and decode logic.
`timescale 1ns/1ps
module pc_next_unit
  import fetch_decode_pkg::*;
(
  input wire logic [20:0] pc,
  input wire logic [15:0] first_word,
  input wire logic [15:0] cur_word,
  input wire logic sel_abs,
  input wire logic sel_rel,
  output logic [20:0] pc_next
);

  // Absolute jumps win over relative ones; both never select together.
  always_comb
  begin
    if (sel_abs)
      pc_next = abs_target(first_word, cur_word); // RL4
    else if (sel_rel)
      pc_next = rel_target(pc, cur_word); // RL5
    else
      pc_next = pc + PC_STEP; // RL3
  end

endmodule : pc_next_unit

// [logic/instruction_word_fetch_decode.sv]
// Instruction word fetch and decode with two-word instruction handling.
// Function
// RL1: Program memory byte addressed, one or two words.
// RL2: Instruction words start at even byte addresses.
// RL3: Counter steps two bytes, bit zero reads zero.
// RL4: Absolute targets load counter bits 20 to 1.
// RL5: Relative offsets count words, not bytes.
// RL6: Four two-word instructions; second word escape-prefixed.
// RL7: Escape word after its first word supplies literal.
// RL8: Lone escape word executes as no-operation.
// RL9: Pending flag cleared on skip, branch, reset.
`timescale 1ns/1ps
module instruction_word_fetch_decode
  import fetch_decode_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  output logic [20:0] PM_ADDR,
  output logic PM_REQ,
  input wire logic [15:0] PM_WORD,
  input wire logic PM_VALID,
  input wire logic SKIP_NEXT,
  output logic EXEC_VALID,
  output logic EXEC_NOP,
  output logic [15:0] EXEC_WORD,
  output logic [11:0] EXEC_LITERAL,
  output logic EXEC_TWO_WORD,
  output logic [20:0] PC_OUT,
  output logic PENDING_SECOND
);

  typedef struct packed {
    fetch_state_e st;
    logic [20:0] pc;
    logic pending;
    logic [15:0] first;
    logic exec_valid;
    logic exec_nop;
    logic [15:0] exec_word;
    logic [11:0] exec_lit;
    logic exec_two;
  } dec_s;

  localparam dec_s DEC_RESET = '{
    st: ST_FETCH,
    pc: PC_RESET,
    pending: 1'b0,
    first: 16'h0000,
    exec_valid: 1'b0,
    exec_nop: 1'b0,
    exec_word: 16'h0000,
    exec_lit: 12'h000,
    exec_two: 1'b0
  };

  dec_s dec_reg;
  dec_s dec_next;
  word_class_e cls;
  logic accept;
  logic pair_ok;
  logic sel_abs;
  logic sel_rel;
  logic [20:0] pc_calc;

  // A word is taken on the cycle the memory answers a pending request.
  assign accept = (dec_reg.st == ST_WAIT) && PM_VALID;
  assign cls = classify(PM_WORD);
  assign pair_ok = dec_reg.pending && (cls == CL_ESC);

  // Jump targets complete only when the escape word follows its call or goto word.
  assign sel_abs = accept && pair_ok && (classify(dec_reg.first) inside {CL_CALL, CL_GOTO});
  // A branch after a lone first word still branches; that first word is dropped.
  assign sel_rel = accept && (cls == CL_BRA); // RL5

  pc_next_unit u_pc_next (
    .pc(dec_reg.pc),
    .first_word(dec_reg.first),
    .cur_word(PM_WORD),
    .sel_abs(sel_abs),
    .sel_rel(sel_rel),
    .pc_next(pc_calc)
  );

  // Requests are held off while a skip is pending so the skipped word is never fetched.
  assign PM_REQ = (dec_reg.st == ST_FETCH) && !SKIP_NEXT; // RL1
  assign PM_ADDR = {dec_reg.pc[20:1], 1'b0}; // RL2
  assign PC_OUT = {dec_reg.pc[20:1], 1'b0}; // RL3
  assign PENDING_SECOND = dec_reg.pending;
  assign EXEC_VALID = dec_reg.exec_valid;
  assign EXEC_NOP = dec_reg.exec_nop;
  assign EXEC_WORD = dec_reg.exec_word;
  assign EXEC_LITERAL = dec_reg.exec_lit;
  assign EXEC_TWO_WORD = dec_reg.exec_two;

  // Sequencer and decoder; execute strobes last one cycle.
  always_comb
  begin
    dec_next = dec_reg;
    dec_next.exec_valid = 1'b0;
    dec_next.exec_nop = 1'b0;
    case (dec_reg.st)
      ST_FETCH:
      begin
        if (SKIP_NEXT)
        begin
          // Skipping drops any half-seen pair so a lone second word becomes a no-op.
          dec_next.pc = dec_reg.pc + PC_STEP; // RL3
          dec_next.pending = 1'b0; // RL9
        end
        else
          dec_next.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (accept)
        begin
          dec_next.st = ST_FETCH;
          dec_next.pc = pc_calc;
          dec_next.pending = 1'b0; // RL9
          if (pair_ok)
          begin
            dec_next.exec_valid = 1'b1; // RL7
            dec_next.exec_word = dec_reg.first;
            dec_next.exec_lit = PM_WORD[11:0];
            dec_next.exec_two = 1'b1;
          end
          else if (cls == CL_ESC)
            dec_next.exec_nop = 1'b1; // RL8
          else if (is_two_word(cls))
          begin
            dec_next.pending = 1'b1; // RL6
            dec_next.first = PM_WORD;
          end
          else
          begin
            dec_next.exec_valid = 1'b1;
            dec_next.exec_word = PM_WORD;
            dec_next.exec_lit = 12'h000;
            dec_next.exec_two = 1'b0;
          end
        end
      end
      default:
        dec_next = DEC_RESET;
    endcase
  end

  // State register; reset restarts fetch at the reset vector.
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      dec_reg <= DEC_RESET;
    else
      dec_reg <= dec_next;
  end

  // The counter never points at an odd byte.
  property p_pc_even;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (PC_OUT[0] == 1'b0) && (PM_ADDR == PC_OUT);
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("odd program counter"); // RL2

  // A plain word advances the counter by two bytes.
  property p_seq_step;
    @(posedge CORE_CLK) disable iff (!RST_N)
    accept && !sel_abs && !sel_rel |=> PC_OUT == $past(PC_OUT) + PC_STEP;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("counter step wrong"); // RL3

  // A completed call or goto loads the word target.
  property p_abs_target;
    @(posedge CORE_CLK) disable iff (!RST_N)
    sel_abs |=> PC_OUT == {$past(dec_reg.first[7:0]), $past(PM_WORD[11:0]), 1'b0};
  endproperty
  a_abs_target: assert property (p_abs_target) else $error("absolute target wrong"); // RL4

  // A relative branch moves from the next word by twice its offset.
  property p_rel_target;
    @(posedge CORE_CLK) disable iff (!RST_N)
    sel_rel |=> PC_OUT == $past(PC_OUT) + PC_STEP + {{9{$past(PM_WORD[10])}},
      $past(PM_WORD[10:0]), 1'b0};
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("relative target wrong"); // RL5

  // A first word of a pair waits for its second without executing.
  property p_pair_wait;
    @(posedge CORE_CLK) disable iff (!RST_N)
    accept && !dec_reg.pending && is_two_word(cls) |=> PENDING_SECOND && !EXEC_VALID
      && !EXEC_NOP;
  endproperty
  a_pair_wait: assert property (p_pair_wait) else $error("pair start not held"); // RL6

  // A matched second word hands its literal to the first.
  property p_literal;
    @(posedge CORE_CLK) disable iff (!RST_N)
    accept && pair_ok |=> EXEC_VALID && EXEC_TWO_WORD && !PENDING_SECOND
      && (EXEC_LITERAL == $past(PM_WORD[11:0]));
  endproperty
  a_literal: assert property (p_literal) else $error("literal not delivered"); // RL7

  // A lone escape word gives one no-op and nothing else.
  property p_lone_nop;
    @(posedge CORE_CLK) disable iff (!RST_N)
    accept && !dec_reg.pending && (cls == CL_ESC) |=> EXEC_NOP && !EXEC_VALID ##1 !EXEC_NOP;
  endproperty
  a_lone_nop: assert property (p_lone_nop) else $error("lone escape not a no-op"); // RL8

  // A skip drops the pending pair and passes over one word without a fetch.
  property p_skip_clear;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (dec_reg.st == ST_FETCH) && SKIP_NEXT |-> !PM_REQ ##1 !PENDING_SECOND
      && (PC_OUT == $past(PC_OUT) + PC_STEP);
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("skip did not clear pair"); // RL9

  // Each request is one cycle and is followed by a wait for its word.
  property p_req_wait;
    @(posedge CORE_CLK) disable iff (!RST_N)
    PM_REQ |=> !PM_REQ && (dec_reg.st == ST_WAIT);
  endproperty
  a_req_wait: assert property (p_req_wait) else $error("request not followed by wait"); // RL1

endmodule : instruction_word_fetch_decode

// [test/prog_word_memory.sv]
// Behavioural program memory that answers word fetches after a random wait.
`timescale 1ns/1ps
module prog_word_memory
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [20:0] addr,
  input wire logic stall,
  output logic valid,
  output logic [15:0] word
);
  logic [15:0] mem [0:63];
  logic busy;

  // A request stays open over stall cycles; between deliveries the data lines
  // toggle so that a stale word can never pass for a fresh one.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      valid <= 1'b0;
      word <= 16'h0000;
    end
    else if ((req || busy) && !stall)
    begin
      busy <= 1'b0;
      valid <= 1'b1;
      word <= mem[addr[6:1]];
    end
    else
    begin
      busy <= busy | req;
      valid <= 1'b0;
      word <= ~word;
    end
  end
endmodule : prog_word_memory

// [test/testbench.sv]
// Self-checking bench for the instruction word fetch and decode block.
`timescale 1ns/1ps
module testbench;
  import fetch_decode_pkg::*;
  typedef struct packed {
    logic nop;
    logic two;
    logic [15:0] word;
    logic [11:0] lit;
    logic [20:0] pc;
  } ev_s;
  logic CORE_CLK, RST_N, SKIP_NEXT, PM_REQ, PM_VALID, EXEC_VALID, EXEC_NOP;
  logic EXEC_TWO_WORD, PENDING_SECOND, stall, exp_pend;
  logic [20:0] PM_ADDR, PC_OUT;
  logic [15:0] PM_WORD, EXEC_WORD, first, x;
  logic [11:0] EXEC_LITERAL;
  logic [31:0] rnd, rs;
  int failures, n_checks, w, sk, pend;
  ev_s q[$];
  ev_s e, ev;
  localparam logic [15:0] PROG [0:21] = '{16'h6600, 16'hc123, 16'hf456, 16'h2400,
    16'h6601, 16'hc123, 16'hf456, 16'hee12, 16'hf034, 16'hec00, 16'hf00c, 16'h0000,
    16'hd003, 16'hef00, 16'hf014, 16'h0000, 16'hd7fc, 16'h0000, 16'h0000, 16'h0000,
    16'hc0aa, 16'h2400};

  instruction_word_fetch_decode dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .PM_ADDR(PM_ADDR), .PM_REQ(PM_REQ), .PM_WORD(PM_WORD), .PM_VALID(PM_VALID),
    .SKIP_NEXT(SKIP_NEXT), .EXEC_VALID(EXEC_VALID), .EXEC_NOP(EXEC_NOP),
    .EXEC_WORD(EXEC_WORD), .EXEC_LITERAL(EXEC_LITERAL), .EXEC_TWO_WORD(EXEC_TWO_WORD),
    .PC_OUT(PC_OUT), .PENDING_SECOND(PENDING_SECOND));
  prog_word_memory pm (.clk(CORE_CLK), .rst_n(RST_N), .req(PM_REQ), .addr(PM_ADDR),
    .stall(stall), .valid(PM_VALID), .word(PM_WORD));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // Free-running core clock at 200 MHz.
  initial
  begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  // Builds the program, runs the reference model, then lets the design run it.
  initial
  begin
    RST_N = 1'b0;
    SKIP_NEXT = 1'b0;
    stall = 1'b0;
    rnd = 32'hde982d04;
    rs = 32'hde982d04;
    for (int i = 0; i < 64; i++)
    begin
      rnd = xs(rnd);
      pm.mem[i] = (i < 22) ? PROG[i] : {4'(rnd[31:16] % 6), rnd[11:0]};
    end
    pm.mem[54] = 16'hef00;
    pm.mem[55] = 16'hf036;
    // Reference: a skip or a branch drops a pending first word, and a lone
    // escape word executes as a no-op.
    while (q.size() < 60)
    begin
      x = pm.mem[w];
      if (sk)
      begin
        sk = 0;
        pend = 0;
        w++;
      end
      else if (x[15:12] == 4'hf)
      begin
        e = '{!pend, pend, first, pend ? x[11:0] : 12'h000, 21'h0};
        w = (pend && (first[15:8] == 8'hec || first[15:8] == 8'hef)) ?
          int'({first[7:0], x[11:0]}) : w + 1;
        e.pc = 21'(2 * w);
        q.push_back(e);
        pend = 0;
      end
      else if (x[15:8] inside {8'hec, 8'hef, 8'hee} || x[15:12] == 4'hc)
      begin
        pend = 1;
        first = x;
        w++;
      end
      else if (x[15:11] == 5'h1a)
      begin
        pend = 0;
        w = w + 1 + int'($signed(x[10:0]));
        q.push_back('{1'b0, 1'b0, x, 12'h000, 21'(2 * w)});
      end
      else
      begin
        pend = 0;
        q.push_back('{1'b0, 1'b0, x, 12'h000, 21'(2 * w + 2)});
        sk = int'(x[15:8] == 8'h66 && !x[0]);
        w++;
      end
    end
    repeat (4) @(posedge CORE_CLK);
    chk("reset_pc", 32'h0, 32'(PC_OUT));
    chk("reset_pending", 32'h0, 32'(PENDING_SECOND));
    chk("reset_req", 32'h1, 32'(PM_REQ));
    RST_N <= 1'b1;
    for (int i = 0; i < 5000 && q.size() > 0; i++)
      @(posedge CORE_CLK);
    chk("events_left", 32'h0, 32'(q.size()));
    conclude();
  end

  // Random memory stalls, skip requests and the compare at every delivery.
  always @(posedge CORE_CLK)
  begin
    rs <= xs(rs);
    stall <= rs[0] & rs[1];
    SKIP_NEXT <= PM_VALID && PM_WORD[15:8] == 8'h66 && !PM_WORD[0];
    // A taken first word of a pair raises the pending level; any other taken word drops it.
    if (!RST_N)
      exp_pend <= 1'b0;
    else if (PM_VALID)
      exp_pend <= (PM_WORD[15:8] inside {8'hec, 8'hef, 8'hee}) || (PM_WORD[15:12] == 4'hc);
    if (RST_N)
    begin
      chk("pc_bit0", 32'h0, 32'(PC_OUT[0]));
      chk("pending_level", 32'(exp_pend), 32'(PENDING_SECOND));
      if (PM_REQ)
        chk("addr", 32'(PC_OUT), 32'(PM_ADDR));
      if ((EXEC_VALID || EXEC_NOP) && q.size() > 0)
      begin
        ev = q.pop_front();
        chk("nop", 32'(ev.nop), 32'(EXEC_NOP));
        chk("pc", 32'(ev.pc), 32'(PC_OUT));
        chk("pending", 32'h0, 32'(PENDING_SECOND));
        if (!ev.nop)
        begin
          chk("word", 32'(ev.word), 32'(EXEC_WORD));
          chk("literal", 32'(ev.lit), 32'(EXEC_LITERAL));
          chk("two_word", 32'(ev.two), 32'(EXEC_TWO_WORD));
        end
      end
    end
  end

  // Watchdog well beyond the few hundred cycles the program needs.
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    chk("watchdog", 32'h0, 32'h1);
    conclude();
  end
endmodule : testbench
